// file: design/conditional_branch_eval.sv
// conditional relative branch evaluator: flag test and pc target
`timescale 1ns/100ps
// Operation
// - carry-clear branch jumps to pc plus offset plus one only when carry is zero.
// - unsigned same-or-higher branch jumps exactly when carry is zero, like carry-clear.
// - unsigned lower branch jumps only when carry is one.
// - minus branch jumps when negative is one and falls through otherwise.
// - plus branch jumps when negative is zero and falls through otherwise.
// - signed greater-or-equal branch jumps when negative xor overflow is zero.
// - signed less-than branch jumps when negative xor overflow is one.
// - every branch completes in one or two cycles depending on the test.
module conditional_branch_eval #(
  parameter int unsigned PC_W  = 16,
  parameter int unsigned OFF_W = 7
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rstn,
  // request from the decoder
  input  wire logic                       issue,
  input  wire branch_pkg::branch_op_t     op,
  input  wire logic [OFF_W-1:0]           offset,
  input  wire logic [PC_W-1:0]            pc,
  input  wire branch_pkg::status_flags_t  flags,
  // answer to the pc update logic
  output logic                            busy_q,
  output logic                            done_q,
  output logic                            taken_q,
  output logic                            pc_load_q,
  output logic [PC_W-1:0]                 target_q,
  output logic                            flag_we_q
);

  // ----------------------------------------------------------------
  // condition decode
  // ----------------------------------------------------------------
  // one decode for every selector; the spare code 7 always falls through
  function automatic logic cond_met(input branch_pkg::branch_op_t o,
                                    input branch_pkg::status_flags_t f);
    logic nv;
    nv = f.negative ^ f.overflow;
    unique case (o)
      branch_pkg::jump_when_carry_low: cond_met = ~f.carry;
      branch_pkg::jump_unsigned_ge:    cond_met = ~f.carry;
      branch_pkg::jump_unsigned_lt:    cond_met = f.carry;
      branch_pkg::jump_when_negative:  cond_met = f.negative;
      branch_pkg::jump_when_positive:  cond_met = ~f.negative;
      branch_pkg::jump_signed_ge:      cond_met = ~nv;
      branch_pkg::jump_signed_lt:      cond_met = nv;
      default:                         cond_met = 1'b0;         // code 7 never branches
    endcase
  endfunction

  typedef enum logic [1:0] {
    st_idle     = 2'b00,
    st_redirect = 2'b01
  } state_t;

  state_t          state_q;
  state_t          state_d;
  logic            accept;
  logic            hit;
  logic [PC_W-1:0] off_ext;
  logic [PC_W-1:0] seq_pc;
  logic [PC_W-1:0] jump_pc;
  logic [PC_W-1:0] target_d;

  // ----------------------------------------------------------------
  // target arithmetic, wraps at the pc width
  // ----------------------------------------------------------------
  // requests during the redirect cycle are dropped; decoder watches busy
  assign accept   = issue && (state_q == st_idle);
  assign hit      = cond_met(op, flags);
  assign off_ext  = PC_W'($signed(offset));
  assign seq_pc   = PC_W'(pc + PC_W'(1));
  assign jump_pc  = PC_W'(seq_pc + off_ext);
  assign target_d = hit ? jump_pc : seq_pc;
  assign state_d  = (accept && hit) ? st_redirect : st_idle;

  // ----------------------------------------------------------------
  // sequencing: fall-through answers next edge, taken one edge later
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      state_q   <= st_idle;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      taken_q   <= 1'b0;
      pc_load_q <= 1'b0;
      target_q  <= '0;
      flag_we_q <= branch_pkg::RST_FLAG;
    end
    else
    begin
      state_q   <= state_d;
      busy_q    <= (state_d == st_redirect);
      done_q    <= (accept && !hit) || (state_q == st_redirect);
      taken_q   <= (accept && !hit) ? 1'b0 : (state_q == st_redirect);
      pc_load_q <= (state_q == st_redirect);
      flag_we_q <= branch_pkg::RST_FLAG;
      if (accept)
      begin
        target_q <= target_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_redirect;
    busy_q && !done_q && !pc_load_q;
  endsequence

  sequence s_land(logic [PC_W-1:0] t);
    done_q && taken_q && pc_load_q && (target_q == t);
  endsequence

  property p_taken_two;
    logic [PC_W-1:0] t;
    @(posedge clock) disable iff (!rstn)
      (accept && hit, t = jump_pc) |=> s_redirect ##1 s_land(t);
  endproperty
  a_taken_two: assert property (p_taken_two) else $error("taken branch not two cycles");

  property p_fall_one;
    logic [PC_W-1:0] t;
    @(posedge clock) disable iff (!rstn)
      (accept && !hit, t = seq_pc) |=> done_q && !taken_q && !pc_load_q && target_q == t;
  endproperty
  a_fall_one: assert property (p_fall_one) else $error("fall-through not one cycle");

  property p_carry_low;
    @(posedge clock) disable iff (!rstn)
      accept && (op == branch_pkg::jump_when_carry_low || op == branch_pkg::jump_unsigned_ge)
      |=> busy_q == !$past(flags.carry);
  endproperty
  a_carry_low: assert property (p_carry_low) else $error("carry-clear decision wrong");

  property p_unsigned_ge;
    @(posedge clock) disable iff (!rstn)
      accept && op == branch_pkg::jump_unsigned_ge && flags.carry |=> done_q && !taken_q;
  endproperty
  a_unsigned_ge: assert property (p_unsigned_ge) else $error("same-or-higher taken");

  property p_unsigned_lt;
    @(posedge clock) disable iff (!rstn)
      accept && op == branch_pkg::jump_unsigned_lt |=> busy_q == $past(flags.carry);
  endproperty
  a_unsigned_lt: assert property (p_unsigned_lt) else $error("lower decision wrong");

  property p_negative;
    @(posedge clock) disable iff (!rstn)
      accept && op == branch_pkg::jump_when_negative |=> ##1 pc_load_q == $past(flags.negative, 2);
  endproperty
  a_negative: assert property (p_negative) else $error("minus decision wrong");

  property p_positive;
    @(posedge clock) disable iff (!rstn)
      accept && op == branch_pkg::jump_when_positive |=> busy_q != $past(flags.negative);
  endproperty
  a_positive: assert property (p_positive) else $error("plus decision wrong");

  property p_signed_ge;
    @(posedge clock) disable iff (!rstn)
      accept && op == branch_pkg::jump_signed_ge
      |=> busy_q == !($past(flags.negative) ^ $past(flags.overflow));
  endproperty
  a_signed_ge: assert property (p_signed_ge) else $error("signed ge decision wrong");

  property p_signed_lt;
    @(posedge clock) disable iff (!rstn)
      accept && op == branch_pkg::jump_signed_lt
      |=> busy_q == ($past(flags.negative) ^ $past(flags.overflow));
  endproperty
  a_signed_lt: assert property (p_signed_lt) else $error("signed lt decision wrong");

  property p_no_flag_write;
    @(posedge clock) disable iff (!rstn)
      (done_q || busy_q) |-> !flag_we_q;
  endproperty
  a_no_flag_write: assert property (p_no_flag_write) else $error("branch wrote a flag");

  // redirect lasts one cycle; an issue seen there must not stretch it
  property p_busy_once;
    @(posedge clock) disable iff (!rstn)
      busy_q |=> !busy_q && done_q && taken_q && pc_load_q;
  endproperty
  a_busy_once: assert property (p_busy_once) else $error("redirect cycle not single");

  // the pc load strobe only ever rides on a taken answer
  property p_load_taken;
    @(posedge clock) disable iff (!rstn)
      pc_load_q |-> done_q && taken_q && !busy_q;
  endproperty
  a_load_taken: assert property (p_load_taken) else $error("stray pc load");

  // target stands between accepted requests so pc logic may read it late
  property p_target_hold;
    @(posedge clock) disable iff (!rstn)
      !accept |=> $stable(target_q);
  endproperty
  a_target_hold: assert property (p_target_hold) else $error("target moved while idle");

  // spare selector code behaves as a one-cycle fall-through
  property p_code_spare;
    @(posedge clock) disable iff (!rstn)
      accept && op == branch_pkg::branch_op_t'(3'h7) |=> done_q && !taken_q && !busy_q;
  endproperty
  a_code_spare: assert property (p_code_spare) else $error("spare code branched");

  // reset clears every answer; no disable here, reset is what is watched
  property p_reset_quiet;
    @(posedge clock)
      !rstn |=> !busy_q && !done_q && !taken_q && !pc_load_q && !flag_we_q && target_q == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("answer left after reset");

endmodule

// file: design/branch_pkg.sv
// shared types and constants for the conditional branch evaluator
package branch_pkg;

  // ----------------------------------------------------------------
  // branch selectors
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    jump_when_carry_low = 3'h0,
    jump_unsigned_ge    = 3'h1,
    jump_unsigned_lt    = 3'h2,
    jump_when_negative  = 3'h3,
    jump_when_positive  = 3'h4,
    jump_signed_ge      = 3'h5,
    jump_signed_lt      = 3'h6
  } branch_op_t;

  // ----------------------------------------------------------------
  // status flags tested by the branches
  // ----------------------------------------------------------------
  typedef struct packed {
    logic carry;
    logic negative;
    logic overflow;
  } status_flags_t;

  // ----------------------------------------------------------------
  // timing and reset values
  // ----------------------------------------------------------------
  localparam int unsigned FALL_CYCLES  = 1;
  localparam int unsigned TAKEN_CYCLES = 2;
  localparam logic        RST_FLAG     = 1'b0;

endpackage

// file: sim/pc_model.sv
// partner model: program counter that follows the branch answers
`timescale 1ns/100ps
module pc_model #(
  parameter logic [15:0] START = 16'h0100
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // answer from the evaluator
  input  wire logic        done_q,
  input  wire logic [15:0] target_q,
  // current program counter
  output logic [15:0]      pc_q
);
  // load on every completion; fall-through target is pc plus one
  always_ff @(posedge clock)
    if (!rstn)
      pc_q <= START;
    else if (done_q)
      pc_q <= target_q;
endmodule

// file: sim/conditional_branch_eval_tb.sv
// self-checking bench for the conditional branch evaluator
`timescale 1ns/100ps
module conditional_branch_eval_tb;
  logic                      clock, rstn, issue;
  branch_pkg::branch_op_t    op;
  logic [6:0]                offset;
  logic [15:0]               pc, target_q;
  branch_pkg::status_flags_t flags;
  logic                      busy_q, done_q, taken_q, pc_load_q, flag_we_q;
  int                        fail_count, cmp_count;

  conditional_branch_eval dut_u (.clock(clock), .rstn(rstn), .issue(issue), .op(op),
    .offset(offset), .pc(pc), .flags(flags), .busy_q(busy_q), .done_q(done_q),
    .taken_q(taken_q), .pc_load_q(pc_load_q), .target_q(target_q), .flag_we_q(flag_we_q));
  pc_model model_u (.clock(clock), .rstn(rstn), .done_q(done_q), .target_q(target_q),
    .pc_q(pc));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // one branch; h holds issue into the busy cycle, which must be ignored
  task automatic go(input logic [2:0] o, input logic [2:0] f, input logic [6:0] k,
                    input logic tk, input logic h);
    logic [15:0] e;
    logic [15:0] ec;
    int n;
    @(posedge clock) #1;
    e = pc + 16'h0001 + (tk ? {{9{k[6]}}, k} : 16'h0000);
    op = branch_pkg::branch_op_t'(o);
    flags = f;
    offset = k;
    issue = 1'b1;
    @(posedge clock) #1;
    n = 1;
    chk("busy", {15'h0, tk}, {15'h0, busy_q});
    if (h)
    begin
      @(posedge clock) #1;
      n++;
      chk("busy held", 16'h0000, {15'h0, busy_q});
    end
    issue = 1'b0;
    while (done_q !== 1'b1 && n < 4)
    begin
      @(posedge clock) #1;
      n++;
    end
    ec = tk ? 16'(branch_pkg::TAKEN_CYCLES) : 16'(branch_pkg::FALL_CYCLES);
    chk("taken", {15'h0, tk}, {15'h0, taken_q});
    chk("pc load", {15'h0, tk}, {15'h0, pc_load_q});
    chk("cycles", ec, n[15:0]);
    chk("target", e, target_q);
    chk("flag write", 16'h0000, {15'h0, flag_we_q});
    repeat (3)
    begin
      @(posedge clock) #1;
      chk("extra done", 16'h0000, {15'h0, done_q});
    end
  endtask

  task automatic t_carry();
    go(3'h0, 3'b000, 7'h3F, 1'b1, 1'b0);
    go(3'h0, 3'b100, 7'h3F, 1'b0, 1'b0);
    go(3'h1, 3'b011, 7'h40, 1'b1, 1'b0);
    go(3'h1, 3'b100, 7'h40, 1'b0, 1'b0);
    go(3'h2, 3'b100, 7'h7F, 1'b1, 1'b1);
    go(3'h2, 3'b011, 7'h7F, 1'b0, 1'b0);
    $display("carry test finished");
  endtask

  task automatic t_sign();
    go(3'h3, 3'b010, 7'h01, 1'b1, 1'b0);
    go(3'h3, 3'b101, 7'h01, 1'b0, 1'b0);
    go(3'h4, 3'b101, 7'h40, 1'b1, 1'b0);
    go(3'h4, 3'b010, 7'h40, 1'b0, 1'b0);
    $display("sign test finished");
  endtask

  task automatic t_signed();
    go(3'h5, 3'b011, 7'h10, 1'b1, 1'b0);
    go(3'h5, 3'b001, 7'h10, 1'b0, 1'b0);
    go(3'h6, 3'b010, 7'h70, 1'b1, 1'b1);
    go(3'h6, 3'b111, 7'h70, 1'b0, 1'b0);
    $display("signed test finished");
  endtask

  // reset cut into the busy cycle of a taken branch, then recovery
  task automatic t_reset();
    @(posedge clock) #1;
    op = branch_pkg::jump_when_carry_low;
    flags = 3'b000;
    offset = 7'h05;
    issue = 1'b1;
    @(posedge clock) #1;
    issue = 1'b0;
    chk("busy before reset", 16'h0001, {15'h0, busy_q});
    rstn = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("busy in reset", 16'h0000, {15'h0, busy_q});
    chk("done in reset", 16'h0000, {15'h0, done_q});
    chk("pc load in reset", 16'h0000, {15'h0, pc_load_q});
    chk("target in reset", 16'h0000, target_q);
    rstn = 1'b1;
    repeat (3)
    begin
      @(posedge clock) #1;
      chk("done after reset", 16'h0000, {15'h0, done_q});
    end
    go(3'h7, 3'b000, 7'h05, 1'b0, 1'b0);
    go(3'h0, 3'b000, 7'h05, 1'b1, 1'b0);
    $display("reset test finished");
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, stimulus and watchdog
  // ------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial
  begin
    rstn = 1'b0;
    issue = 1'b0;
    op = branch_pkg::jump_when_carry_low;
    offset = 7'h00;
    flags = 3'b000;
    repeat (12) @(posedge clock);
    #1 rstn = 1'b1;
    t_carry();
    t_sign();
    t_signed();
    t_reset();
    summarize();
  end

  // about 110 cycles expected; cut a hang well past that
  initial
  begin
    #20000;
    fail_count++;
    summarize();
  end
endmodule
